/* bsp_fifo.sv */
// bsp_fifo: small synchronous fifo with valid/ready on both sides.
// assumes one clock and a synchronous active-low reset; data width and depth
// are parameters that size the storage and the counters.
`timescale 1ns/1ps

module bsp_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 32
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
    logic                    ird;
    logic                    ov;
    logic [W-1:0]            od;
  } bsp_fifo_st_t;

  bsp_fifo_st_t st_reg;
  bsp_fifo_st_t st_next;
  logic         push;
  logic         pop;
  logic         take;

  // ==========================================================
  // next state
  // storage count excludes the output word, so in_ready is honest
  always_comb begin
    st_next = st_reg;
    push    = in_valid && st_reg.ird;
    pop     = st_reg.ov && out_ready;
    take    = (!st_reg.ov || pop) && (st_reg.cnt != '0);
    if (push) begin
      st_next.mem[st_reg.wp] = in_data;
      st_next.wp             = AW'(st_reg.wp + 1'b1);
    end
    if (take) begin
      st_next.od = st_reg.mem[st_reg.rp];
      st_next.rp = AW'(st_reg.rp + 1'b1);
      st_next.ov = 1'b1;
    end else if (pop) begin
      st_next.ov = 1'b0;
    end
    st_next.cnt = (AW+1)'(st_reg.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, take});
    st_next.ird = st_next.cnt < (AW+1)'(DEPTH); // registered, so never overruns
    if (!rst_n) begin
      st_next = '0;
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk) begin
    st_reg <= st_next;
  end

  assign in_ready  = st_reg.ird;
  assign out_data  = st_reg.od;
  assign out_valid = st_reg.ov;
endmodule

/* bsp_pins_top.sv */
// bsp_pins_top: pin logic of three buffered serial ports plus their constants.
// assumes mclk for the user side, link_clk (faster than any external shift
// clock) for pin logic, and a pad ring that resolves the *_oe_n enables.
//
// Function
// - the receive shift clock pin is input or output by choice and is an input after reset.
// - the receiver samples receive data on its shift clock, internal or external.
// - receive data enters only through the receive data pin, which never drives.
// - the receive frame sync pin is input or output by choice and is an input after reset.
// - a receive frame sync pulse starts one word; whoever drives the sync must pulse it.
// - the transmitter shifts data out on the transmit data pin with its shift clock.
// - the transmit shift clock pin is input or output by choice and is an input after reset.
// - the transmit shift clock pin floats whenever the output-disable input is low.
// - transmit data floats when idle, in reset and while output-disable is low.
// - transmit frame sync is input or output, input after reset, and its pulse starts a word only if one is queued.

`timescale 1ns/1ps

package bsp_pkg;
  localparam int NPORTS      = 3;
  localparam int WORD_W      = 16;
  localparam int FIFO_DEPTH  = 32;
  localparam int CNT_W       = 5;
  // internal shift clock: half period in link clocks
  localparam logic [1:0] DIV_HALF = 2'h2;
  // internal receive frame: one sync bit then the word
  localparam logic [CNT_W-1:0] FRAME_BITS = 5'h11;
  localparam logic [CNT_W-1:0] WORD_BITS  = 5'h10;
  // mode bit positions, 1 = pin is an output
  localparam int MODE_RX_CLK = 0;
  localparam int MODE_RX_FS  = 1;
  localparam int MODE_TX_CLK = 2;
  localparam int MODE_TX_FS  = 3;
  localparam logic [3:0] MODE_RESET = 4'h0;

  typedef struct packed {
    logic [3:0]        mode;
    logic [WORD_W-1:0] tx_hold;
    logic              req_tog;
    logic              ack_s1;
    logic              ack_s2;
    logic              rx_s1;
    logic              rx_s2;
    logic              rx_s3;
    logic [WORD_W-1:0] rx_word;
    logic              rx_valid;
  } bsp_user_t;

  typedef struct packed {
    logic [3:0]        mode_s1;
    logic [3:0]        mode_s2;
    logic              rclk_s1, rclk_s2, rclk_s3;
    logic              rfs_s1, rfs_s2;
    logic              rd_s1, rd_s2;
    logic              tclk_s1, tclk_s2, tclk_s3;
    logic              tfs_s1, tfs_s2;
    logic              req_s1, req_s2;
    logic [1:0]        div;
    logic              int_clk;
    logic              rx_act;
    logic [CNT_W-1:0]  rx_cnt;
    logic [CNT_W-1:0]  rx_fcnt;
    logic [WORD_W-1:0] rx_sh;
    logic [WORD_W-1:0] rx_word;
    logic              rx_tog;
    logic              rx_fs_o;
    logic              tx_pend;
    logic [WORD_W-1:0] tx_buf;
    logic              ack_tog;
    logic              tx_act;
    logic [CNT_W-1:0]  tx_cnt;
    logic [WORD_W-1:0] tx_sh;
    logic              tx_fs_o;
    logic              tx_d_o;
    logic              rclk_oe_n, rfs_oe_n, tclk_oe_n, tfs_oe_n, td_oe_n;
  } bsp_link_t;

  typedef struct packed {
    logic rst_s1, rst_s2;
    logic off_s1, off_s2;
  } bsp_shared_t;
endpackage

module bsp_pins_top (
  input  wire logic                                        mclk,
  input  wire logic                                        rstn,
  input  wire logic                                        link_clk,
  input  wire logic                                        off_n,
  input  wire logic [bsp_pkg::NPORTS-1:0][3:0]             mode_in,
  input  wire logic [bsp_pkg::NPORTS-1:0][bsp_pkg::WORD_W-1:0] tx_word,
  input  wire logic [bsp_pkg::NPORTS-1:0]                  tx_valid,
  output logic      [bsp_pkg::NPORTS-1:0]                  tx_ready,
  output logic      [bsp_pkg::NPORTS-1:0][bsp_pkg::WORD_W-1:0] rx_word,
  output logic      [bsp_pkg::NPORTS-1:0]                  rx_valid,
  input  wire logic [bsp_pkg::NPORTS-1:0]                  rx_shift_clock_i,
  output logic      [bsp_pkg::NPORTS-1:0]                  rx_shift_clock_o,
  output logic      [bsp_pkg::NPORTS-1:0]                  rx_shift_clock_oe_n,
  input  wire logic [bsp_pkg::NPORTS-1:0]                  rx_serial_data,
  input  wire logic [bsp_pkg::NPORTS-1:0]                  rx_frame_sync_i,
  output logic      [bsp_pkg::NPORTS-1:0]                  rx_frame_sync_o,
  output logic      [bsp_pkg::NPORTS-1:0]                  rx_frame_sync_oe_n,
  input  wire logic [bsp_pkg::NPORTS-1:0]                  tx_shift_clock_i,
  output logic      [bsp_pkg::NPORTS-1:0]                  tx_shift_clock_o,
  output logic      [bsp_pkg::NPORTS-1:0]                  tx_shift_clock_oe_n,
  output logic      [bsp_pkg::NPORTS-1:0]                  tx_serial_data,
  output logic      [bsp_pkg::NPORTS-1:0]                  tx_serial_data_oe_n,
  input  wire logic [bsp_pkg::NPORTS-1:0]                  tx_frame_sync_i,
  output logic      [bsp_pkg::NPORTS-1:0]                  tx_frame_sync_o,
  output logic      [bsp_pkg::NPORTS-1:0]                  tx_frame_sync_oe_n
);

  // ==========================================================
  // shared link-side synchronisers: reset and output-disable
  bsp_pkg::bsp_shared_t sh_reg;
  bsp_pkg::bsp_shared_t sh_next;

  // reset enters the link domain through two flops, so pins release late
  always_comb begin
    sh_next        = sh_reg;
    sh_next.rst_s1 = rstn;
    sh_next.rst_s2 = sh_reg.rst_s1;
    sh_next.off_s1 = off_n;
    sh_next.off_s2 = sh_reg.off_s1;
  end

  always_ff @(posedge link_clk) begin
    sh_reg <= sh_next;
  end

  // ==========================================================
  // one port per loop pass, nothing shared but reset and disable
  for (genvar p = 0; p < bsp_pkg::NPORTS; p++) begin : g_port
    bsp_pkg::bsp_user_t usr_reg;
    bsp_pkg::bsp_user_t usr_next;
    bsp_pkg::bsp_link_t lnk_reg;
    bsp_pkg::bsp_link_t lnk_next;
    logic [bsp_pkg::WORD_W-1:0] f_data;
    logic                       f_valid;
    logic                       f_ready;
    logic                       rise_r, fall_r, rise_t, fall_t;
    logic                       rfs_v, tfs_v, div_wrap;

    // transmit words queue here; full fifo stalls the user via tx_ready
    bsp_fifo #(
      .W     (bsp_pkg::WORD_W),
      .DEPTH (bsp_pkg::FIFO_DEPTH)
    ) u_fifo (
      .clk       (mclk),
      .rst_n     (rstn),
      .in_data   (tx_word[p]),
      .in_valid  (tx_valid[p]),
      .in_ready  (tx_ready[p]),
      .out_data  (f_data),
      .out_valid (f_valid),
      .out_ready (f_ready)
    );

    // ========================================================
    // user side: mode capture and word handshakes
    // one word in flight to the link at a time; the toggle pairs it
    always_comb begin
      usr_next          = usr_reg;
      f_ready           = usr_reg.req_tog == usr_reg.ack_s2;
      usr_next.mode     = mode_in[p];
      usr_next.ack_s1   = lnk_reg.ack_tog;
      usr_next.ack_s2   = usr_reg.ack_s1;
      usr_next.rx_s1    = lnk_reg.rx_tog;
      usr_next.rx_s2    = usr_reg.rx_s1;
      usr_next.rx_s3    = usr_reg.rx_s2;
      usr_next.rx_valid = 1'b0;
      if (f_valid && f_ready) begin
        usr_next.tx_hold = f_data;
        usr_next.req_tog = !usr_reg.req_tog;
      end
      // link word is stable for a whole word time after its toggle
      if (usr_reg.rx_s2 != usr_reg.rx_s3) begin
        usr_next.rx_word  = lnk_reg.rx_word;
        usr_next.rx_valid = 1'b1;
      end
      if (!rstn) begin
        usr_next      = '0;
        usr_next.mode = bsp_pkg::MODE_RESET;
      end
    end

    always_ff @(posedge mclk) begin
      usr_reg <= usr_next;
    end

    // ========================================================
    // link side: shift clock events
    // external clocks are seen through two flops, edges on the second
    assign div_wrap = lnk_reg.div == 2'(bsp_pkg::DIV_HALF - 2'h1);
    assign rise_r = lnk_reg.mode_s2[bsp_pkg::MODE_RX_CLK]
                    ? (div_wrap && !lnk_reg.int_clk)
                    : (lnk_reg.rclk_s2 && !lnk_reg.rclk_s3);
    assign fall_r = lnk_reg.mode_s2[bsp_pkg::MODE_RX_CLK]
                    ? (div_wrap && lnk_reg.int_clk)
                    : (!lnk_reg.rclk_s2 && lnk_reg.rclk_s3);
    assign rise_t = lnk_reg.mode_s2[bsp_pkg::MODE_TX_CLK]
                    ? (div_wrap && !lnk_reg.int_clk)
                    : (lnk_reg.tclk_s2 && !lnk_reg.tclk_s3);
    assign fall_t = lnk_reg.mode_s2[bsp_pkg::MODE_TX_CLK]
                    ? (div_wrap && lnk_reg.int_clk)
                    : (!lnk_reg.tclk_s2 && lnk_reg.tclk_s3);
    assign rfs_v = lnk_reg.mode_s2[bsp_pkg::MODE_RX_FS] ? lnk_reg.rx_fs_o : lnk_reg.rfs_s2;
    assign tfs_v = lnk_reg.mode_s2[bsp_pkg::MODE_TX_FS] ? lnk_reg.tx_fs_o : lnk_reg.tfs_s2;

    // link side next state: receiver, transmitter, pin enables
    always_comb begin
      lnk_next         = lnk_reg;
      lnk_next.mode_s1 = usr_reg.mode;
      lnk_next.mode_s2 = lnk_reg.mode_s1;
      lnk_next.rclk_s1 = rx_shift_clock_i[p];
      lnk_next.rclk_s2 = lnk_reg.rclk_s1;
      lnk_next.rclk_s3 = lnk_reg.rclk_s2;
      lnk_next.rfs_s1  = rx_frame_sync_i[p];
      lnk_next.rfs_s2  = lnk_reg.rfs_s1;
      lnk_next.rd_s1   = rx_serial_data[p];
      lnk_next.rd_s2   = lnk_reg.rd_s1;
      lnk_next.tclk_s1 = tx_shift_clock_i[p];
      lnk_next.tclk_s2 = lnk_reg.tclk_s1;
      lnk_next.tclk_s3 = lnk_reg.tclk_s2;
      lnk_next.tfs_s1  = tx_frame_sync_i[p];
      lnk_next.tfs_s2  = lnk_reg.tfs_s1;
      lnk_next.req_s1  = usr_reg.req_tog;
      lnk_next.req_s2  = lnk_reg.req_s1;
      // internal shift clock divider, runs free
      lnk_next.div = div_wrap ? 2'h0 : 2'(lnk_reg.div + 2'h1);
      if (div_wrap) begin
        lnk_next.int_clk = !lnk_reg.int_clk;
      end
      // internal receive sync: one bit high every frame
      if (rise_r) begin
        lnk_next.rx_fs_o = lnk_reg.rx_fcnt == '0;
        lnk_next.rx_fcnt = (lnk_reg.rx_fcnt == bsp_pkg::FRAME_BITS - 5'h01)
                           ? '0 : 5'(lnk_reg.rx_fcnt + 5'h01);
      end
      // receiver samples on falling edges, one bit after the sync
      if (fall_r) begin
        if (lnk_reg.rx_act) begin
          lnk_next.rx_sh  = {lnk_reg.rx_sh[bsp_pkg::WORD_W-2:0], lnk_reg.rd_s2};
          lnk_next.rx_cnt = 5'(lnk_reg.rx_cnt - 5'h01);
          if (lnk_reg.rx_cnt == 5'h01) begin
            lnk_next.rx_word = {lnk_reg.rx_sh[bsp_pkg::WORD_W-2:0], lnk_reg.rd_s2};
            lnk_next.rx_tog  = !lnk_reg.rx_tog;
            lnk_next.rx_act  = 1'b0;
          end
        end else if (rfs_v) begin
          lnk_next.rx_act = 1'b1;
          lnk_next.rx_cnt = bsp_pkg::WORD_BITS;
        end
      end
      // take a word from the user side when the buffer is free
      if (!lnk_reg.tx_pend && (lnk_reg.req_s2 != lnk_reg.ack_tog)) begin
        lnk_next.tx_pend = 1'b1;
        lnk_next.tx_buf  = usr_reg.tx_hold;
        lnk_next.ack_tog = lnk_reg.req_s2;
      end
      // transmitter drives on rising edges; own sync asks only with a word
      if (rise_t) begin
        lnk_next.tx_fs_o = lnk_reg.tx_pend && !lnk_reg.tx_act;
        if (lnk_reg.tx_act) begin
          if (lnk_reg.tx_cnt != '0) begin
            lnk_next.tx_d_o = lnk_reg.tx_sh[bsp_pkg::WORD_W-1];
            lnk_next.tx_sh  = {lnk_reg.tx_sh[bsp_pkg::WORD_W-2:0], 1'b0};
            lnk_next.tx_cnt = 5'(lnk_reg.tx_cnt - 5'h01);
          end else begin
            lnk_next.tx_act = 1'b0;
          end
        end
      end
      // sync with nothing queued is ignored: the pin just stays released
      if (fall_t && tfs_v && !lnk_reg.tx_act && lnk_reg.tx_pend) begin
        lnk_next.tx_act  = 1'b1;
        lnk_next.tx_sh   = lnk_reg.tx_buf;
        lnk_next.tx_cnt  = bsp_pkg::WORD_BITS;
        lnk_next.tx_pend = 1'b0;
      end
      // enables, low means driving
      lnk_next.rclk_oe_n = !lnk_reg.mode_s2[bsp_pkg::MODE_RX_CLK];
      lnk_next.rfs_oe_n  = !lnk_reg.mode_s2[bsp_pkg::MODE_RX_FS];
      lnk_next.tclk_oe_n = !(lnk_reg.mode_s2[bsp_pkg::MODE_TX_CLK] && sh_reg.off_s2);
      lnk_next.tfs_oe_n  = !(lnk_reg.mode_s2[bsp_pkg::MODE_TX_FS] && sh_reg.off_s2);
      lnk_next.td_oe_n   = !(lnk_next.tx_act && sh_reg.off_s2);
      if (!sh_reg.rst_s2) begin
        lnk_next           = '0;
        lnk_next.rclk_oe_n = 1'b1;
        lnk_next.rfs_oe_n  = 1'b1;
        lnk_next.tclk_oe_n = 1'b1;
        lnk_next.tfs_oe_n  = 1'b1;
        lnk_next.td_oe_n   = 1'b1;
      end
    end

    always_ff @(posedge link_clk) begin
      lnk_reg <= lnk_next;
    end

    // ========================================================
    // pin and user outputs, each straight from a flop
    assign rx_word[p]             = usr_reg.rx_word;
    assign rx_valid[p]            = usr_reg.rx_valid;
    assign rx_shift_clock_o[p]    = lnk_reg.int_clk;
    assign rx_shift_clock_oe_n[p] = lnk_reg.rclk_oe_n;
    assign rx_frame_sync_o[p]     = lnk_reg.rx_fs_o;
    assign rx_frame_sync_oe_n[p]  = lnk_reg.rfs_oe_n;
    assign tx_shift_clock_o[p]    = lnk_reg.int_clk;
    assign tx_shift_clock_oe_n[p] = lnk_reg.tclk_oe_n;
    assign tx_serial_data[p]      = lnk_reg.tx_d_o;
    assign tx_serial_data_oe_n[p] = lnk_reg.td_oe_n;
    assign tx_frame_sync_o[p]     = lnk_reg.tx_fs_o;
    assign tx_frame_sync_oe_n[p]  = lnk_reg.tfs_oe_n;
  end
endmodule

/* bsp_pins_props.sv */
// bsp_pins_props: concurrent checks on the serial port pin enables and the receive valid pulse.
// assumes it is bound into bsp_pins_top and sees only its ports.
`timescale 1ns/1ps

module bsp_pins_props (
  input wire logic            mclk,
  input wire logic            rstn,
  input wire logic            link_clk,
  input wire logic            off_n,
  input wire logic [2:0][3:0] mode_in,
  input wire logic [2:0]      rx_valid,
  input wire logic [2:0]      rx_shift_clock_oe_n,
  input wire logic [2:0]      rx_frame_sync_oe_n,
  input wire logic [2:0]      tx_shift_clock_oe_n,
  input wire logic [2:0]      tx_serial_data_oe_n,
  input wire logic [2:0]      tx_frame_sync_i,
  input wire logic [2:0]      tx_frame_sync_oe_n
);
  // ==========
  // sequences
  // reset seen at three link edges: two synchroniser flops plus the state register
  sequence s_rst_held;
    !rstn [*3];
  endsequence
  // off_n low long enough for its two flops plus the output register
  sequence s_off_held;
    !off_n [*5];
  endsequence

  // ==========
  // reset and output disable
  AST_RST_REL: assert property (@(posedge link_clk) s_rst_held |=>
    &{rx_shift_clock_oe_n, rx_frame_sync_oe_n, tx_shift_clock_oe_n,
      tx_serial_data_oe_n, tx_frame_sync_oe_n})
    else $error("pin driven during reset");
  AST_OFF_TCLK: assert property (@(posedge link_clk) disable iff (!rstn)
    s_off_held |-> &tx_shift_clock_oe_n)
    else $error("tx clock driven while off");
  AST_OFF_TDATA: assert property (@(posedge link_clk) disable iff (!rstn)
    s_off_held |-> &{tx_serial_data_oe_n, tx_frame_sync_oe_n})
    else $error("tx data or sync driven while off");

  // ==========
  // pin direction follows the mode bits
  AST_RCLK_IN: assert property (@(posedge link_clk) disable iff (!rstn)
    !mode_in[2][0] [*8] |-> rx_shift_clock_oe_n[2])
    else $error("rx clock driven as input");
  AST_RFS_OUT: assert property (@(posedge link_clk) disable iff (!rstn)
    mode_in[2][1] [*8] |-> !rx_frame_sync_oe_n[2])
    else $error("rx sync not driven as output");
  AST_TCLK_IN: assert property (@(posedge link_clk) disable iff (!rstn)
    !mode_in[2][2] [*8] |-> tx_shift_clock_oe_n[2])
    else $error("tx clock driven as input");
  AST_TFS_IN: assert property (@(posedge link_clk) disable iff (!rstn)
    !mode_in[2][3] [*8] |-> tx_frame_sync_oe_n[2])
    else $error("tx sync driven as input");

  // ==========
  // transfers
  AST_TD_START: assert property (@(posedge link_clk) disable iff (!rstn)
    $fell(tx_serial_data_oe_n[0]) |-> $past(tx_frame_sync_i[0], 3))
    else $error("tx data driven without a sync");
  AST_RX_ONE: assert property (@(posedge mclk) disable iff (!rstn)
    rx_valid[0] |=> !rx_valid[0])
    else $error("rx valid longer than one cycle");
endmodule

bind bsp_pins_top bsp_pins_props props_u (.*);

/* bsp_codec_model.sv */
// bsp_codec_model: external codec on one port, supplying clock and syncs.
// assumes the bench routes its clock and sync to pins set as inputs.
`timescale 1ns/1ps

module bsp_codec_model #(
  parameter realtime HALF = 30.0
) (
  output logic      sclk,
  output logic      fs,
  output logic      rxd,
  input  wire logic txd,
  input  wire logic txd_oe_n
);
  // clock stands low between frames, as a real codec gates it
  initial begin
    sclk = 1'b0;
    fs = 1'b0;
    rxd = 1'b0;
  end

  // one frame: sync for one bit, then 16 bits msb first both ways
  task automatic frame(input logic [15:0] w, output logic [15:0] got, output logic drove);
    drove = 1'b0;
    got = 16'h0000;
    #HALF sclk = 1'b1;
    fs = 1'b1;
    #HALF sclk = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      #HALF sclk = 1'b1;
      fs = 1'b0;
      rxd = w[i];
      #HALF sclk = 1'b0;
      got[i] = txd;
      drove = drove | !txd_oe_n;
    end
    #HALF sclk = 1'b1;
    #HALF sclk = 1'b0;
    rxd = ~rxd; // released line must not keep the last bit
  endtask
endmodule

/* testbench.sv */
// testbench: drives three serial ports from the user side and codec models.
// assumes bsp_pkg, bsp_fifo, bsp_pins_top and the model are compiled first.
`timescale 1ns/1ps

module testbench;
  logic            mclk, rstn, link_clk, off_n;
  logic [2:0][3:0] mode_in;
  logic [2:0][15:0] tx_word, rx_word;
  logic [2:0]      tx_valid, tx_ready, rx_valid, rx_serial_data;
  logic [2:0]      rx_shift_clock_i, rx_shift_clock_o, rx_shift_clock_oe_n;
  logic [2:0]      rx_frame_sync_i, rx_frame_sync_o, rx_frame_sync_oe_n;
  logic [2:0]      tx_shift_clock_i, tx_shift_clock_o, tx_shift_clock_oe_n;
  logic [2:0]      tx_frame_sync_i, tx_frame_sync_o, tx_frame_sync_oe_n;
  logic [2:0]      tx_serial_data, tx_serial_data_oe_n, m_ck, m_fs;
  int              n_fail, n_checks;

  // ==========
  // clocks, pins and instances
  always #2 mclk = ~mclk;
  // link clock offset so its edges never line up with mclk
  initial begin
    link_clk = 1'b0;
    #0.7;
    forever #3 link_clk = ~link_clk;
  end
  // a pin follows the device when it drives, else the codec
  assign rx_shift_clock_i = (rx_shift_clock_oe_n & m_ck) | (~rx_shift_clock_oe_n & rx_shift_clock_o);
  assign tx_shift_clock_i = (tx_shift_clock_oe_n & m_ck) | (~tx_shift_clock_oe_n & tx_shift_clock_o);
  assign rx_frame_sync_i = (rx_frame_sync_oe_n & m_fs) | (~rx_frame_sync_oe_n & rx_frame_sync_o);
  assign tx_frame_sync_i = (tx_frame_sync_oe_n & m_fs) | (~tx_frame_sync_oe_n & tx_frame_sync_o);
  bsp_pins_top dut_u (.*);
  for (genvar i = 0; i < 3; i++) begin : g
    bsp_codec_model m (.sclk(m_ck[i]), .fs(m_fs[i]), .rxd(rx_serial_data[i]),
                       .txd(tx_serial_data[i]), .txd_oe_n(tx_serial_data_oe_n[i]));
  end

  // ==========
  // shared tasks
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic give_up(input string nm);
    n_fail++;
    $display("timeout waiting for %s", nm);
    finish_test();
  endtask
  // offer one word; called at a falling edge, valid held for one rising edge,
  // then one idle edge so back-to-back calls never rewrite valid in one step
  task automatic push(input int p, input logic [15:0] w);
    int k;
    k = 0;
    while (tx_ready[p] !== 1'b1) begin
      @(negedge mclk);
      k++;
      if (k > 200) give_up("tx_ready");
    end
    tx_word[p] = w;
    tx_valid[p] = 1'b1;
    @(negedge mclk);
    tx_valid[p] = 1'b0;
    @(negedge mclk);
  endtask

  // ==========
  // scenarios
  task automatic t_reset;
    check("rx clock oe_n", rx_shift_clock_oe_n, 3'h7);
    check("rx sync oe_n", rx_frame_sync_oe_n, 3'h7);
    check("tx clock oe_n", tx_shift_clock_oe_n, 3'h7);
    check("tx data oe_n", tx_serial_data_oe_n, 3'h7);
    check("tx sync oe_n", tx_frame_sync_oe_n, 3'h7);
    $display("test reset done");
  endtask
  task automatic t_ext;
    logic [15:0] g0, g1;
    logic        d0, d1;
    push(0, 16'hA5C3);
    push(0, 16'h0F01);
    push(1, 16'h8001);
    repeat (30) @(negedge mclk);
    fork
      g[0].m.frame(16'h9C36, g0, d0);
      g[1].m.frame(16'h7E81, g1, d1);
    join
    repeat (20) @(negedge mclk);
    check("rx word 0", rx_word[0], 16'h9C36);
    check("rx word 1", rx_word[1], 16'h7E81);
    check("tx word 0", g0, 16'hA5C3);
    check("tx word 1", g1, 16'h8001);
    check("tx idle oe_n", tx_serial_data_oe_n, 3'h7);
    // second queued word on port 0, nothing queued on port 1
    g[0].m.frame(16'h1234, g0, d0);
    g[1].m.frame(16'h4321, g1, d1);
    repeat (20) @(negedge mclk);
    check("tx word 0 next", g0, 16'h0F01);
    check("tx 1 drove empty", d1, 1'b0);
    check("rx word 1 next", rx_word[1], 16'h4321);
    $display("test external clock done");
  endtask
  task automatic t_int;
    logic [15:0] got;
    int          k, b;
    logic        on;
    logic        s;
    // receive line held high so the internal frame carries a known word
    g[2].m.rxd = 1'b1;
    mode_in[2] = 4'hF;
    push(2, 16'hC35A);
    k = 0;
    b = 16;
    on = 1'b0;
    // bits are driven on rising, so take each on the falling edge
    while (b > 0) begin
      @(negedge tx_shift_clock_o[2]);
      k++;
      if (k > 200) give_up("internal frame");
      if (on) begin
        b--;
        got[b] = tx_serial_data[2];
      end
      else if (tx_frame_sync_o[2] === 1'b1) on = 1'b1;
    end
    check("tx word 2", got, 16'hC35A);
    check("port 2 oe_n", {rx_shift_clock_oe_n[2], rx_frame_sync_oe_n[2],
                          tx_shift_clock_oe_n[2], tx_frame_sync_oe_n[2]}, 4'h0);
    // a word may finish during the tx loop; the next one follows within a frame
    k = 0;
    while (rx_valid[2] !== 1'b1) begin
      @(negedge mclk);
      k++;
      if (k > 300) give_up("internal rx word");
    end
    check("rx word 2", rx_word[2], 16'hFFFF);
    // internal sync repeats every 17 bits, about 102 mclk
    s = 1'b0;
    repeat (120) begin
      @(negedge mclk);
      s = s | rx_frame_sync_o[2];
    end
    check("rx sync pulse", s, 1'b1);
    check("shift clocks agree", rx_shift_clock_o[2], tx_shift_clock_o[2]);
    check("tx 2 idle oe_n", tx_serial_data_oe_n[2], 1'b1);
    $display("test internal clock done");
  endtask
  task automatic t_off;
    int k;
    off_n = 1'b0;
    repeat (10) @(negedge mclk);
    check("tx pins off", {tx_shift_clock_oe_n, tx_frame_sync_oe_n, tx_serial_data_oe_n},
          9'h1FF);
    check("rx clock kept", rx_shift_clock_oe_n[2], 1'b0);
    // a queued word must not reach the pin while disabled
    push(2, 16'h5AA5);
    k = 0;
    repeat (400) begin
      @(negedge mclk);
      if (tx_serial_data_oe_n[2] !== 1'b1) k++;
    end
    check("data driven off", k, 32'h0);
    off_n = 1'b1;
    $display("test output disable done");
  endtask

  // ==========
  // main sequence; five mclk of reset cover three link edges, enough for the sync flops
  initial begin
    mclk = 1'b0;
    rstn = 1'b0;
    off_n = 1'b1;
    mode_in = 12'h000;
    tx_valid = 3'h0;
    tx_word = 48'h0;
    n_fail = 0;
    n_checks = 0;
    repeat (5) @(negedge mclk);
    t_reset();
    rstn = 1'b1;
    t_ext();
    t_int();
    t_off();
    finish_test();
  end
endmodule
